// >>> include/dvm_params.svh
// Register offsets, field positions, reset values and codes for the DAC volume and mix-gain slice
// Assumes inclusion by bare name from the package and the design modules
`ifndef DVM_PARAMS_SVH
`define DVM_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DVM_OFS_SOFTSTEP 8'h28
`define DVM_OFS_COUPLING 8'h29
`define DVM_OFS_LEFT_DAC 8'h2b
`define DVM_OFS_RIGHT_DAC 8'h2c
`define DVM_OFS_MIX_GAIN 8'h2d
// ----------------------------------------
// Fields and resets
// ----------------------------------------
`define DVM_MUTE_BIT 7
`define DVM_ROUTE_BIT 7
`define DVM_CODE_MSB 6
`define DVM_DAC_RESET 8'h80
`define DVM_MIX_RESET 8'h00
`define DVM_CTRL_RESET 2'h0
`define DVM_FIELD2_MSB 1
// ----------------------------------------
// Coupling and stepping encodings
// ----------------------------------------
`define DVM_CPL_L_FOLLOWS_R 2'h1
`define DVM_CPL_R_FOLLOWS_L 2'h2
`define DVM_STEP_PER_SAMPLE 2'h0
`define DVM_STEP_PER_TWO 2'h1
`define DVM_STEP_OFF 2'h2
// ----------------------------------------
// Output-stage gain mapping
// ----------------------------------------
`define DVM_LAST_GAIN_CODE 7'h75
`define DVM_MUTE_ATTEN 10'h3ff
`endif

// >>> include/dvm_pkg.sv
// Types shared by the DAC volume and mix-gain slice
// Assumes dvm_params.svh is on the include path
package dvm_pkg;
`include "dvm_params.svh"
	typedef struct packed {
		logic mute;
		logic [6:0] code;
	} dvm_dac_vol_s;
	typedef struct packed {
		logic route;
		logic [6:0] code;
	} dvm_mix_gain_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dvm_reg_req_s;
	typedef enum logic [1:0] {DVM_RAMP_IDLE, DVM_RAMP_WAIT, DVM_RAMP_STEP} dvm_ramp_e;
endpackage

// >>> rtl/dvm_gain_map.sv
// Output-stage volume element: maps a seven-bit gain code to attenuation in tenths of a dB
// Assumes the caller applies mute when the mute flag is high
`timescale 1ns/100ps
`include "dvm_params.svh"
module dvm_gain_map
	import dvm_pkg::*;
(
	input wire logic [6:0] code,
	output logic [9:0] atten_tenths,
	output logic muted
);
	// Non-uniform codes 71 to 117 held as a table; codes up to 36 are a plain 0.5 dB ladder, 37 to 70 the same ladder plus 0.1 dB
	always_comb
	begin
		muted = (code > `DVM_LAST_GAIN_CODE);
		atten_tenths = `DVM_MUTE_ATTEN;
		if (code <= 7'd36)
			atten_tenths = 10'(code) * 10'd5;
		else if (code <= 7'd70)
			atten_tenths = 10'(code) * 10'd5 + 10'd1;
		else
		begin
			case (code)
				7'd71: atten_tenths = 10'd357;
				7'd72: atten_tenths = 10'd361;
				7'd73: atten_tenths = 10'd367;
				7'd74: atten_tenths = 10'd371;
				7'd75: atten_tenths = 10'd377;
				7'd76: atten_tenths = 10'd382;
				7'd77: atten_tenths = 10'd387;
				7'd78: atten_tenths = 10'd392;
				7'd79: atten_tenths = 10'd397;
				7'd80: atten_tenths = 10'd402;
				7'd81: atten_tenths = 10'd407;
				7'd82: atten_tenths = 10'd412;
				7'd83: atten_tenths = 10'd417;
				7'd84: atten_tenths = 10'd422;
				7'd85: atten_tenths = 10'd427;
				7'd86: atten_tenths = 10'd432;
				7'd87: atten_tenths = 10'd438;
				7'd88: atten_tenths = 10'd443;
				7'd89: atten_tenths = 10'd448;
				7'd90: atten_tenths = 10'd452;
				7'd91: atten_tenths = 10'd458;
				7'd92: atten_tenths = 10'd462;
				7'd93: atten_tenths = 10'd467;
				7'd94: atten_tenths = 10'd474;
				7'd95: atten_tenths = 10'd479;
				7'd96: atten_tenths = 10'd482;
				7'd97: atten_tenths = 10'd487;
				7'd98: atten_tenths = 10'd493;
				7'd99: atten_tenths = 10'd500;
				7'd100: atten_tenths = 10'd503;
				7'd101: atten_tenths = 10'd510;
				7'd102: atten_tenths = 10'd514;
				7'd103: atten_tenths = 10'd518;
				7'd104: atten_tenths = 10'd522;
				7'd105: atten_tenths = 10'd527;
				7'd106: atten_tenths = 10'd537;
				7'd107: atten_tenths = 10'd542;
				7'd108: atten_tenths = 10'd553;
				7'd109: atten_tenths = 10'd567;
				7'd110: atten_tenths = 10'd583;
				7'd111: atten_tenths = 10'd602;
				7'd112: atten_tenths = 10'd627;
				7'd113: atten_tenths = 10'd643;
				7'd114: atten_tenths = 10'd662;
				7'd115: atten_tenths = 10'd687;
				7'd116: atten_tenths = 10'd722;
				7'd117: atten_tenths = 10'd783;
				default: atten_tenths = `DVM_MUTE_ATTEN;
			endcase
		end
	end
endmodule

// >>> rtl/dvm_volume_regs.sv
// DAC digital volume and left-headphone line-input mix gain registers
// Assumes a synchronous register port on clk and a one-cycle sample strobe from the DAC clock logic
`timescale 1ns/100ps
`include "dvm_params.svh"
module dvm_volume_regs
	import dvm_pkg::*;
#(
	parameter int NUM_ELEMENTS = 7
)
(
	input wire logic clk,
	input wire logic reset,
	input wire dvm_reg_req_s req,
	input wire logic sample_strobe,
	output logic [7:0] rdata,
	output logic rvalid,
	output dvm_dac_vol_s left_dac_vol,
	output dvm_dac_vol_s right_dac_vol,
	output logic mix_route,
	output logic [9:0] mix_atten,
	output logic mix_mute,
	output logic mix_settling
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	dvm_dac_vol_s left_reg_r, left_reg_nxt, right_reg_r, right_reg_nxt;
	dvm_mix_gain_s mix_reg_r, mix_reg_nxt;
	logic [1:0] coupling_r, coupling_nxt, step_mode_r, step_mode_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] l, input logic [7:0] r,
		input logic [7:0] m, input logic [1:0] c, input logic [1:0] s);
		case (a)
			`DVM_OFS_LEFT_DAC: read_mux = l;
			`DVM_OFS_RIGHT_DAC: read_mux = r;
			`DVM_OFS_MIX_GAIN: read_mux = m;
			`DVM_OFS_COUPLING: read_mux = {6'h00, c};
			`DVM_OFS_SOFTSTEP: read_mux = {6'h00, s};
			default: read_mux = 8'h00;
		endcase
	endfunction

	always_comb
	begin
		left_reg_nxt = left_reg_r;
		right_reg_nxt = right_reg_r;
		mix_reg_nxt = mix_reg_r;
		coupling_nxt = coupling_r;
		step_mode_nxt = step_mode_r;
		rvalid_nxt = req.rd;
		rdata_nxt = req.rd ? read_mux(req.addr, left_reg_r, right_reg_r, mix_reg_r, coupling_r, step_mode_r)
			: rdata_r;
		if (req.wr)
		begin
			case (req.addr)
				`DVM_OFS_LEFT_DAC: left_reg_nxt = req.wdata;
				`DVM_OFS_RIGHT_DAC: right_reg_nxt = req.wdata;
				`DVM_OFS_MIX_GAIN: mix_reg_nxt = req.wdata;
				`DVM_OFS_COUPLING: coupling_nxt = req.wdata[`DVM_FIELD2_MSB:0];
				`DVM_OFS_SOFTSTEP: step_mode_nxt = req.wdata[`DVM_FIELD2_MSB:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			left_reg_r <= `DVM_DAC_RESET;
			right_reg_r <= `DVM_DAC_RESET;
			mix_reg_r <= `DVM_MIX_RESET;
			coupling_r <= `DVM_CTRL_RESET;
			step_mode_r <= `DVM_CTRL_RESET;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else
		begin
			left_reg_r <= left_reg_nxt;
			right_reg_r <= right_reg_nxt;
			mix_reg_r <= mix_reg_nxt;
			coupling_r <= coupling_nxt;
			step_mode_r <= step_mode_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ----------------------------------------
	// DAC volume, coupled and sample-aligned
	// ----------------------------------------
	dvm_dac_vol_s left_src, right_src, left_app_r, left_app_nxt, right_app_r, right_app_nxt;

	always_comb
	begin
		left_src = (coupling_r == `DVM_CPL_L_FOLLOWS_R) ? right_reg_r : left_reg_r;
		right_src = (coupling_r == `DVM_CPL_R_FOLLOWS_L) ? left_reg_r : right_reg_r;
		// Only on a sample edge, so a sample is never scaled by a half-written code
		left_app_nxt = sample_strobe ? left_src : left_app_r;
		right_app_nxt = sample_strobe ? right_src : right_app_r;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			left_app_r <= `DVM_DAC_RESET;
			right_app_r <= `DVM_DAC_RESET;
		end
		else
		begin
			left_app_r <= left_app_nxt;
			right_app_r <= right_app_nxt;
		end
	end

	// ----------------------------------------
	// Mix gain soft-stepping
	// ----------------------------------------
	// One element instance per mix path; this slice holds only the first of NUM_ELEMENTS
	dvm_ramp_e ramp_r, ramp_nxt;
	logic [6:0] cur_code_r, cur_code_nxt;
	logic half_r, half_nxt;
	logic [9:0] atten_w;
	logic muted_w;
	logic [9:0] atten_r, atten_nxt;
	logic mute_r, mute_nxt, route_r, route_nxt;
	logic settling_r, settling_nxt;

	dvm_gain_map u_map
	(
		.code(cur_code_r),
		.atten_tenths(atten_w),
		.muted(muted_w)
	);

	always_comb
	begin
		ramp_nxt = ramp_r;
		cur_code_nxt = cur_code_r;
		half_nxt = half_r;
		route_nxt = mix_reg_r.route;
		atten_nxt = atten_w;
		mute_nxt = muted_w | ~mix_reg_r.route;
		case (ramp_r)
			DVM_RAMP_IDLE:
			begin
				half_nxt = 1'b0;
				if (cur_code_r != mix_reg_r.code)
				begin
					if (step_mode_r == `DVM_STEP_OFF)
						cur_code_nxt = mix_reg_r.code;
					else
						ramp_nxt = DVM_RAMP_WAIT;
				end
			end
			DVM_RAMP_WAIT:
			begin
				if (sample_strobe)
				begin
					// Two-sample mode waits for every second strobe
					if (step_mode_r == `DVM_STEP_PER_TWO && !half_r)
						half_nxt = 1'b1;
					else
						ramp_nxt = DVM_RAMP_STEP;
				end
			end
			DVM_RAMP_STEP:
			begin
				half_nxt = 1'b0;
				if (cur_code_r < mix_reg_r.code)
					cur_code_nxt = cur_code_r + 7'h01;
				else if (cur_code_r > mix_reg_r.code)
					cur_code_nxt = cur_code_r - 7'h01;
				ramp_nxt = DVM_RAMP_IDLE;
			end
			default: ramp_nxt = DVM_RAMP_IDLE;
		endcase
		// Registered so the status output has no gate in its path
		settling_nxt = (ramp_nxt != DVM_RAMP_IDLE);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ramp_r <= DVM_RAMP_IDLE;
			cur_code_r <= 7'h00;
			half_r <= 1'b0;
			atten_r <= 10'h000;
			mute_r <= 1'b1;
			route_r <= 1'b0;
			settling_r <= 1'b0;
		end
		else
		begin
			ramp_r <= ramp_nxt;
			cur_code_r <= cur_code_nxt;
			half_r <= half_nxt;
			atten_r <= atten_nxt;
			mute_r <= mute_nxt;
			route_r <= route_nxt;
			settling_r <= settling_nxt;
		end
	end

	assign rdata = rdata_r;
	assign rvalid = rvalid_r;
	assign left_dac_vol = left_app_r;
	assign right_dac_vol = right_app_r;
	assign mix_route = route_r;
	assign mix_atten = atten_r;
	assign mix_mute = mute_r;
	assign mix_settling = settling_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_left_write;
		req.wr && req.addr == `DVM_OFS_LEFT_DAC && coupling_r != `DVM_CPL_L_FOLLOWS_R;
	endsequence
	sequence s_next_sample;
		sample_strobe && !req.wr ##1 1'b1;
	endsequence

	a_left_mute_reset: assert property (@(posedge clk) $fell(reset) |-> left_dac_vol.mute)
		else $error("left mute not set after reset");
	a_right_mute_reset: assert property (@(posedge clk) $fell(reset) |-> right_dac_vol.mute)
		else $error("right mute not set after reset");
	sequence s_first_half;
		ramp_r == DVM_RAMP_WAIT && sample_strobe && step_mode_r == `DVM_STEP_PER_TWO && !half_r;
	endsequence

	a_left_on_sample: assert property (@(posedge clk) disable iff (reset)
		s_left_write ##1 s_next_sample |-> left_dac_vol == $past(left_reg_r))
		else $error("left volume not applied on sample");
	a_hold_no_sample: assert property (@(posedge clk) disable iff (reset)
		!$past(sample_strobe) |-> $stable(left_dac_vol) && $stable(right_dac_vol))
		else $error("volume changed off a sample boundary");
	a_coupling_right: assert property (@(posedge clk) disable iff (reset)
		sample_strobe && coupling_r == `DVM_CPL_R_FOLLOWS_L |=> right_dac_vol == $past(left_reg_r))
		else $error("right did not follow left");
	a_right_indep: assert property (@(posedge clk) disable iff (reset)
		sample_strobe && coupling_r == 2'h0 |=> right_dac_vol == $past(right_reg_r))
		else $error("right volume not its own");
	a_route_off_mute: assert property (@(posedge clk) disable iff (reset)
		!mix_reg_r.route |=> mix_mute && !mix_route)
		else $error("unrouted path not muted");
	a_deep_codes_mute: assert property (@(posedge clk) disable iff (reset)
		cur_code_r > `DVM_LAST_GAIN_CODE |=> mix_mute)
		else $error("codes above 117 not muted");
	a_gain_117: assert property (@(posedge clk) disable iff (reset)
		cur_code_r == 7'd117 |=> mix_atten == 10'd783)
		else $error("code 117 not -78.3 dB");
	a_step_off_fast: assert property (@(posedge clk) disable iff (reset)
		ramp_r == DVM_RAMP_IDLE && step_mode_r == `DVM_STEP_OFF && cur_code_r != mix_reg_r.code
		|=> cur_code_r == $past(mix_reg_r.code))
		else $error("stepping off did not apply at once");
	a_step_by_one: assert property (@(posedge clk) disable iff (reset)
		ramp_r == DVM_RAMP_STEP |=> (cur_code_r - $past(cur_code_r) == 7'h01)
		|| ($past(cur_code_r) - cur_code_r == 7'h01) || cur_code_r == $past(cur_code_r))
		else $error("soft step larger than one code");
	a_left_follows: assert property (@(posedge clk) disable iff (reset)
		sample_strobe && coupling_r == `DVM_CPL_L_FOLLOWS_R |=> left_dac_vol == $past(right_reg_r))
		else $error("left did not follow right");
	a_left_readback: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == `DVM_OFS_LEFT_DAC |=> rvalid && rdata == $past(left_reg_r))
		else $error("left volume read back wrong");
	a_mix_readback: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == `DVM_OFS_MIX_GAIN |=> rvalid && rdata == $past(mix_reg_r))
		else $error("mix gain read back wrong");
	a_mix_write: assert property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == `DVM_OFS_MIX_GAIN |=> mix_reg_r == $past(req.wdata))
		else $error("mix gain write lost");
	a_route_on: assert property (@(posedge clk) disable iff (reset)
		mix_reg_r.route |=> mix_route)
		else $error("routed path not connected");
	// Settling is flagged once a mismatch seen in idle starts a ramp
	a_settle_flag: assert property (@(posedge clk) disable iff (reset)
		ramp_r == DVM_RAMP_IDLE && cur_code_r != mix_reg_r.code && step_mode_r != `DVM_STEP_OFF |=> mix_settling)
		else $error("settling not flagged");
	a_half_rate: assert property (@(posedge clk) disable iff (reset)
		s_first_half |=> ramp_r == DVM_RAMP_WAIT && cur_code_r == $past(cur_code_r))
		else $error("two-sample mode stepped on first strobe");
	a_wait_holds: assert property (@(posedge clk) disable iff (reset)
		ramp_r == DVM_RAMP_WAIT && !sample_strobe |=> ramp_r == DVM_RAMP_WAIT && cur_code_r == $past(cur_code_r))
		else $error("gain moved between samples");
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the DAC volume and mix-gain register slice
// Assumes dvm_pkg is compiled first; the bench drives the register port and sample strobe itself
`timescale 1ns/100ps
module tb_top
	import dvm_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	dvm_reg_req_s req = '0;
	logic sample_strobe = 1'b0;
	logic [7:0] rdata;
	logic rvalid;
	dvm_dac_vol_s left_dac_vol;
	dvm_dac_vol_s right_dac_vol;
	logic mix_route;
	logic [9:0] mix_atten;
	logic mix_mute;
	logic mix_settling;
	int num_errors = 0;
	int n_tests = 0;
	logic [6:0] codes [7] = '{7'h00, 7'h01, 7'h24, 7'h25, 7'h57, 7'h74, 7'h75};
	logic [9:0] tenths [7] = '{10'h000, 10'h005, 10'h0b4, 10'h0ba, 10'h1b6, 10'h2d2, 10'h30f};

	always #25 clk = ~clk;

	dvm_volume_regs dut_u (
		.clk(clk),
		.reset(reset),
		.req(req),
		.sample_strobe(sample_strobe),
		.rdata(rdata),
		.rvalid(rvalid),
		.left_dac_vol(left_dac_vol),
		.right_dac_vol(right_dac_vol),
		.mix_route(mix_route),
		.mix_atten(mix_atten),
		.mix_mute(mix_mute),
		.mix_settling(mix_settling)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		if (num_errors == 0 && n_tests > 0)
		begin
			$display("SIMULATION PASSED");
		end
		else
		begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		idle(1);
		req.wr = 1'b0;
		// An edge between calls, so a strobe is never lowered and raised in one step
		idle(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req.rd = 1'b1;
		req.addr = a;
		idle(1);
		req.rd = 1'b0;
		chk({9'h0, rvalid}, 10'h001);
		chk({2'h0, rdata}, {2'h0, exp});
		idle(1);
	endtask

	// One sample period, then let the applied value land
	task automatic strobe;
		sample_strobe = 1'b1;
		idle(1);
		sample_strobe = 1'b0;
		idle(2);
	endtask

	task automatic dac(input logic [7:0] l, input logic [7:0] r);
		chk({2'h0, left_dac_vol}, {2'h0, l});
		chk({2'h0, right_dac_vol}, {2'h0, r});
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		idle(16);
		reset = 1'b0;
		dac(8'h80, 8'h80);
		chk({9'h0, mix_mute}, 10'h001);
		rd(8'h2b, 8'h80);
		rd(8'h2c, 8'h80);
		rd(8'h2d, 8'h00);
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		// DAC volume waits for a sample boundary
		wr(8'h2b, 8'h05);
		idle(3);
		dac(8'h80, 8'h80);
		strobe();
		dac(8'h05, 8'h80);
		wr(8'h2c, 8'h7f);
		strobe();
		dac(8'h05, 8'h7f);
		// Coupling modes, upper bits read back as zero
		wr(8'h29, 8'h01);
		strobe();
		dac(8'h7f, 8'h7f);
		wr(8'h29, 8'hfe);
		rd(8'h29, 8'h02);
		strobe();
		dac(8'h05, 8'h05);
		wr(8'h29, 8'hff);
		strobe();
		dac(8'h05, 8'h7f);
		// Strobe held high across a write lands the new code on the edge after the write
		sample_strobe = 1'b1;
		wr(8'h2b, 8'h0a);
		sample_strobe = 1'b0;
		idle(2);
		dac(8'h0a, 8'h7f);
		// Unmapped offset ignores writes
		wr(8'h2a, 8'h55);
		rd(8'h2a, 8'h00);
		// Mix gain mapping with stepping off
		wr(8'h28, 8'h02);
		for (int i = 0; i < 7; i++)
		begin
			wr(8'h2d, {1'b1, codes[i]});
			idle(4);
			chk(mix_atten, tenths[i]);
			chk({9'h0, mix_mute}, 10'h000);
		end
		rd(8'h2d, 8'hf5);
		wr(8'h2d, 8'hf6);
		idle(4);
		chk({9'h0, mix_mute}, 10'h001);
		wr(8'h2d, 8'hff);
		idle(4);
		chk({9'h0, mix_mute}, 10'h001);
		wr(8'h2d, 8'h05);
		idle(4);
		chk({9'h0, mix_route}, 10'h000);
		chk({9'h0, mix_mute}, 10'h001);
		wr(8'h2d, 8'h80);
		idle(4);
		// One step per sample
		wr(8'h28, 8'h00);
		wr(8'h2d, 8'h84);
		idle(2);
		chk({9'h0, mix_settling}, 10'h001);
		chk(mix_atten, 10'h000);
		repeat (6) strobe();
		chk(mix_atten, 10'h014);
		chk({9'h0, mix_settling}, 10'h000);
		// One step per two samples is slower
		wr(8'h28, 8'h01);
		wr(8'h2d, 8'h80);
		idle(2);
		repeat (4) strobe();
		chk({9'h0, mix_settling}, 10'h001);
		repeat (8) strobe();
		chk(mix_atten, 10'h000);
		chk({9'h0, mix_settling}, 10'h000);
		tally_and_finish();
	end

	// Whole sequence is well under a thousand cycles
	initial
	begin
		#200000;
		num_errors++;
		tally_and_finish();
	end
endmodule
